// ### hw/tag_host_serial_port.sv
// How it works
// - three modes: rf, serial, tunnel
// - rf mode: reader masters, port idle
// - serial mode: host masters, port serves
// - tunnel mode: port relays to host
// - input pin is rx or serial clock
// - data pin is tx or shared data
// - pins only pulled low, else released
// - tunnel command gives one low event pulse
// - uart 38.4 kbps, sync clock 1 Mbps
// - uart also reports event on tx
`timescale 1ns/100ps
`default_nettype none
`include "ths_params.svh"

module tag_host_serial_port
   import ths_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   srst,
   input  wire logic [1:0]             op_mode,
   input  wire logic                   tunnel_cmd,
   input  wire logic                   sel_strap,
   input  wire logic                   rx_pin,
   input  wire logic                   data_out_low_volt_in,
   output logic                        data_out_low_volt_out,
   output logic                        data_out_low_volt_oe,
   input  wire logic                   data_out_high_volt_in,
   output logic                        data_out_high_volt_out,
   output logic                        data_out_high_volt_oe,
   output logic                        event_out_low_volt_out,
   output logic                        event_out_low_volt_oe,
   output logic                        event_out_high_volt_out,
   output logic                        event_out_high_volt_oe,
   input  wire logic                   tx_valid,
   output logic                        tx_ready,
   input  wire logic [`THS_DATA_W-1:0] tx_data,
   output logic                        rx_valid,
   output logic      [`THS_DATA_W-1:0] rx_data,
   output logic                        sync_mode
);
   localparam logic [9:0] BIT_CYC  = 10'(`THS_UART_BIT_CYC - 1);
   localparam logic [9:0] HALF_CYC = 10'(`THS_UART_HALF_CYC - 1);
   localparam logic [5:0] EVT_CYC  = 6'(`THS_EVT_PULSE_CYC);

   logic                   sel_m, sel_s;
   logic                   rx_m, rx_s, rx_d;
   logic [1:0]             dl_m, dl_s;
   logic                   dl_line;
   ths_rx_st_t             rx_st;
   ths_tx_st_t             tx_st;
   logic [9:0]             rx_cnt, tx_cnt;
   logic [2:0]             rx_bit, tx_bit;
   logic [`THS_DATA_W-1:0] rx_sh, tx_sh;
   logic [3:0]             sy_bit;
   logic                   drive;
   logic                   line_low;
   logic                   evt_pend;
   logic [5:0]             evt_cnt;
   logic                   evt_low;
   logic                   port_on;
   logic                   sck_rise, sck_fall;
   logic                   link_idle;
   logic                   f_valid, f_ready;
   logic [`THS_DATA_W-1:0] f_data;
   logic                   evt_take;

   // wired port only active in serial and tunnel modes
   assign port_on   = (op_mode == THS_MODE_SERIAL) || (op_mode == THS_MODE_TUNNEL);
   assign sck_rise  = rx_s && !rx_d;
   assign sck_fall  = !rx_s && rx_d;
   assign link_idle = (rx_st == THS_RX_IDLE) && (tx_st == THS_TX_IDLE) && (sy_bit == 4'h0);
   assign evt_take  = !sync_mode && port_on && (tx_st == THS_TX_IDLE) && evt_pend;
   assign dl_line   = &dl_s;

   ths_fifo
   #(
      .WIDTH (`THS_DATA_W),
      .DEPTH (`THS_FIFO_DEPTH)
   )
   u_fifo
   (
      .clk       (clk),
      .srst      (srst),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .in_data   (tx_data),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_data)
   );

   // either wired variant pulls the shared line low
   always_ff @(posedge clk)
   begin
      sel_m <= sel_strap;
      sel_s <= sel_m;
      rx_m  <= rx_pin;
      rx_s  <= rx_m;
      rx_d  <= rx_s;
      dl_m  <= {data_out_low_volt_in, data_out_high_volt_in};
      dl_s  <= dl_m;
   end

   // strap taken only while the link is quiet
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         sync_mode <= 1'b0;
      end
      else if (link_idle)
      begin
         sync_mode <= sel_s;
      end
   end

   // uart receiver, mid-bit sampling of the input pin
   always_ff @(posedge clk)
   begin
      if (srst || sync_mode || !port_on)
      begin
         rx_st  <= THS_RX_IDLE;
         rx_cnt <= '0;
         rx_bit <= '0;
      end
      else
      begin
         unique case (rx_st)
            THS_RX_IDLE:
            begin
               if (!rx_s)
               begin
                  rx_st  <= THS_RX_START;
                  rx_cnt <= HALF_CYC;
               end
            end
            THS_RX_START:
            begin
               if (rx_cnt != '0)
               begin
                  rx_cnt <= rx_cnt - 1'b1;
               end
               else
               begin
                  rx_st  <= rx_s ? THS_RX_IDLE : THS_RX_DATA;
                  rx_cnt <= BIT_CYC;
                  rx_bit <= '0;
               end
            end
            THS_RX_DATA:
            begin
               if (rx_cnt != '0)
               begin
                  rx_cnt <= rx_cnt - 1'b1;
               end
               else
               begin
                  rx_cnt <= BIT_CYC;
                  rx_bit <= rx_bit + 1'b1;
                  if (rx_bit == 3'h7)
                  begin
                     rx_st <= THS_RX_STOP;
                  end
               end
            end
            THS_RX_STOP:
            begin
               if (rx_cnt != '0)
               begin
                  rx_cnt <= rx_cnt - 1'b1;
               end
               else
               begin
                  rx_st <= THS_RX_IDLE;
               end
            end
         endcase
      end
   end

   // received byte from uart or sampled data line
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rx_sh    <= '0;
         rx_data  <= '0;
         rx_valid <= 1'b0;
      end
      else
      begin
         rx_valid <= 1'b0;
         if (!sync_mode && rx_st == THS_RX_DATA && rx_cnt == '0)
         begin
            rx_sh <= {rx_s, rx_sh[7:1]};
         end
         if (!sync_mode && rx_st == THS_RX_STOP && rx_cnt == '0 && rx_s)
         begin
            rx_data  <= rx_sh;
            rx_valid <= 1'b1;
         end
         if (sync_mode && port_on && !drive && sck_rise)
         begin
            rx_sh <= {dl_line, rx_sh[7:1]};
            if (sy_bit == 4'h7)
            begin
               rx_data  <= {dl_line, rx_sh[7:1]};
               rx_valid <= 1'b1;
            end
         end
      end
   end

   // synchronous bit count per serial clock rising edge
   always_ff @(posedge clk)
   begin
      if (srst || !sync_mode || !port_on)
      begin
         sy_bit <= '0;
      end
      else if (sck_rise)
      begin
         sy_bit <= (sy_bit == 4'h7) ? 4'h0 : sy_bit + 1'b1;
      end
   end

   assign f_ready = port_on && !evt_take && (tx_st == THS_TX_IDLE) &&
                    (!sync_mode || (sy_bit == 4'h0 && rx_s && !sck_rise));

   // transmitter, uart frame or synchronous shift out
   always_ff @(posedge clk)
   begin
      if (srst || !port_on)
      begin
         tx_st  <= THS_TX_IDLE;
         tx_cnt <= '0;
         tx_bit <= '0;
         tx_sh  <= '0;
         drive  <= 1'b0;
      end
      else
      begin
         unique case (tx_st)
            THS_TX_IDLE:
            begin
               // pending event byte goes ahead of data
               if (evt_take)
               begin
                  tx_sh  <= `THS_EVT_CODE;
                  tx_st  <= THS_TX_START;
                  tx_cnt <= BIT_CYC;
               end
               else if (f_valid && f_ready)
               begin
                  tx_sh  <= f_data;
                  tx_bit <= '0;
                  tx_cnt <= BIT_CYC;
                  // device takes the line only at a byte boundary
                  drive  <= sync_mode;
                  tx_st  <= sync_mode ? THS_TX_DATA : THS_TX_START;
               end
            end
            THS_TX_START:
            begin
               if (tx_cnt != '0)
               begin
                  tx_cnt <= tx_cnt - 1'b1;
               end
               else
               begin
                  tx_cnt <= BIT_CYC;
                  tx_bit <= '0;
                  tx_st  <= THS_TX_DATA;
               end
            end
            THS_TX_DATA:
            begin
               if (sync_mode)
               begin
                  // bit 0 stands until the second falling edge
                  if (sck_fall && sy_bit != 4'h0)
                  begin
                     tx_sh <= {1'b1, tx_sh[7:1]};
                  end
                  // line released after the eighth clock
                  if (sck_rise && sy_bit == 4'h7)
                  begin
                     drive <= 1'b0;
                     tx_st <= THS_TX_IDLE;
                  end
               end
               else if (tx_cnt != '0)
               begin
                  tx_cnt <= tx_cnt - 1'b1;
               end
               else
               begin
                  tx_cnt <= BIT_CYC;
                  tx_sh  <= {1'b1, tx_sh[7:1]};
                  tx_bit <= tx_bit + 1'b1;
                  if (tx_bit == 3'h7)
                  begin
                     tx_st <= THS_TX_STOP;
                  end
               end
            end
            THS_TX_STOP:
            begin
               if (tx_cnt != '0)
               begin
                  tx_cnt <= tx_cnt - 1'b1;
               end
               else
               begin
                  tx_st <= THS_TX_IDLE;
               end
            end
         endcase
      end
   end

   // line pulled low for start bit or a zero data bit
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         line_low <= 1'b0;
      end
      else
      begin
         line_low <= port_on && ((tx_st == THS_TX_START) ||
                                 (tx_st == THS_TX_DATA && !tx_sh[0]));
      end
   end

   // tunnel command pulse and uart event flag; set wins
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         evt_cnt  <= '0;
         evt_low  <= 1'b0;
         evt_pend <= 1'b0;
      end
      else
      begin
         if (tunnel_cmd && op_mode == THS_MODE_TUNNEL)
         begin
            evt_cnt <= EVT_CYC;
            evt_low <= 1'b1;
         end
         else if (evt_cnt > 6'h1)
         begin
            evt_cnt <= evt_cnt - 1'b1;
         end
         else
         begin
            evt_cnt <= '0;
            evt_low <= 1'b0;
         end
         evt_pend <= (evt_pend && !evt_take) ||
                     (tunnel_cmd && op_mode == THS_MODE_TUNNEL && !sync_mode);
      end
   end

   // open-drain, one flop per pin class feeds both variants
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         data_out_low_volt_out   <= 1'b0;
         data_out_high_volt_out  <= 1'b0;
         event_out_low_volt_out  <= 1'b0;
         event_out_high_volt_out <= 1'b0;
      end
      else
      begin
         data_out_low_volt_out   <= 1'b0;
         data_out_high_volt_out  <= 1'b0;
         event_out_low_volt_out  <= 1'b0;
         event_out_high_volt_out <= 1'b0;
      end
   end

   assign data_out_low_volt_oe   = line_low;
   assign data_out_high_volt_oe  = line_low;
   assign event_out_low_volt_oe  = evt_low;
   assign event_out_high_volt_oe = evt_low;

endmodule : tag_host_serial_port

`default_nettype wire

// ### hw/ths_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module ths_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
)
(
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW:0]      fill;
   logic [AW:0]      next_fill;
   logic             take;
   logic             push;
   logic             pop;

   // mem feeds a registered output word
   assign push     = in_valid && in_ready;
   assign pop      = (count != '0) && (!out_valid || out_ready);
   assign take      = out_valid && out_ready;
   assign next_fill = fill + (AW+1)'(push) - (AW+1)'(take);

   // words held, output register included; ready comes from a flop
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         fill     <= '0;
         in_ready <= 1'b1;
      end
      else
      begin
         fill     <= next_fill;
         in_ready <= (next_fill != (AW+1)'(DEPTH));
      end
   end

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop)
         begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         out_valid <= 1'b0;
         out_data  <= '0;
      end
      else if (pop)
      begin
         out_valid <= 1'b1;
         out_data  <= mem[rd_ptr];
      end
      else if (out_ready)
      begin
         out_valid <= 1'b0;
      end
   end

endmodule : ths_fifo

`default_nettype wire

// ### hw/ths_params.svh
`ifndef THS_PARAMS_SVH
`define THS_PARAMS_SVH

// system clock and link rates
`define THS_CLK_HZ        20000000
`define THS_UART_BAUD     38400
`define THS_SYNC_MAX_BPS  1000000
// one uart bit, rounded down to whole cycles
`define THS_UART_BIT_CYC  (`THS_CLK_HZ / `THS_UART_BAUD)
`define THS_UART_HALF_CYC (`THS_UART_BIT_CYC / 2)
// event pulse width on the event pins
`define THS_EVT_PULSE_NS  1000
`define THS_CLK_NS        50
`define THS_EVT_PULSE_CYC ((`THS_EVT_PULSE_NS + `THS_CLK_NS - 1) / `THS_CLK_NS)
// byte sent on the uart transmit line to report a tunnel command
`define THS_EVT_CODE      8'hA5
// data path
`define THS_DATA_W        8
`define THS_FIFO_DEPTH    32

`endif

// ### hw/ths_pkg.sv
package ths_pkg;

   typedef enum logic [1:0]
   {
      THS_MODE_RF     = 2'b00,
      THS_MODE_SERIAL = 2'b01,
      THS_MODE_TUNNEL = 2'b10
   } ths_mode_t;

   typedef enum logic [1:0]
   {
      THS_RX_IDLE  = 2'b00,
      THS_RX_START = 2'b01,
      THS_RX_DATA  = 2'b10,
      THS_RX_STOP  = 2'b11
   } ths_rx_st_t;

   typedef enum logic [1:0]
   {
      THS_TX_IDLE  = 2'b00,
      THS_TX_START = 2'b01,
      THS_TX_DATA  = 2'b10,
      THS_TX_STOP  = 2'b11
   } ths_tx_st_t;

endpackage : ths_pkg

// ### verification/tag_host_serial_port_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin failures++; \
   $display("MISMATCH %0t %s", $time, m); end end

module tag_host_serial_port_bench
   import ths_pkg::*;
;
   logic       clk = 1'b0;
   logic       srst = 1'b1;
   logic [1:0] op_mode = 2'b00;
   logic       tunnel_cmd = 1'b0;
   logic       sel_strap = 1'b0;
   logic       tx_valid = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic       rx_pin, line, tx_ready, rx_valid, sync_mode, dlo, dho, elo;
   logic [7:0] rx_data;
   int         failures = 0;
   int         checked = 0;

   always #25 clk = ~clk;

   tag_host_serial_port u_dut (.clk, .srst, .op_mode, .tunnel_cmd, .sel_strap, .rx_pin,
      .data_out_low_volt_in(line), .data_out_low_volt_out(), .data_out_low_volt_oe(dlo),
      .data_out_high_volt_in(line), .data_out_high_volt_out(), .data_out_high_volt_oe(dho),
      .event_out_low_volt_out(), .event_out_low_volt_oe(elo), .event_out_high_volt_out(),
      .event_out_high_volt_oe(), .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_data,
      .sync_mode);

   ths_host_model u_host (.clk, .sync(sel_strap), .dev_low_oe(dlo), .dev_high_oe(dho),
      .rx_pin, .line);

   task automatic conclude;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : conclude

   task automatic wait_rx(input int n, output logic got);
      got = 1'b0;
      for (int i = 0; i < n && !got; i++)
      begin
         @(negedge clk);
         got = (rx_valid === 1'b1);
      end
   endtask : wait_rx

   // data held until taken
   task automatic push_seq(input logic [7:0] base, input int n, output int taken);
      taken = 0;
      tx_valid = 1'b1;
      for (int i = 0; i < n; i++)
      begin
         tx_data = base + 8'(taken);
         if (tx_ready === 1'b1)
            taken++;
         @(negedge clk);
      end
      tx_valid = 1'b0;
   endtask : push_seq

   task automatic t_uart_rx;
      logic got;
      op_mode = THS_MODE_SERIAL;
      fork
         u_host.uart_send(8'h5A, 1'b1);
         wait_rx(6000, got);
      join
      `CHK(got, 1'b1, "uart byte missing")
      `CHK(rx_data, 8'h5A, "uart rx data")
      fork
         u_host.uart_send(8'h33, 1'b0);
         wait_rx(6000, got);
      join
      `CHK(got, 1'b0, "bad stop accepted")
   endtask : t_uart_rx

   task automatic t_tunnel;
      int n;
      tunnel_cmd = 1'b1;
      @(negedge clk);
      tunnel_cmd = 1'b0;
      `CHK(elo, 1'b0, "event outside tunnel")
      @(negedge clk);
      op_mode = THS_MODE_TUNNEL;
      tunnel_cmd = 1'b1;
      @(negedge clk);
      tunnel_cmd = 1'b0;
      `CHK(elo, 1'b1, "event pulse missing")
      push_seq(8'hC1, 2, n);
      `CHK(n, 2, "tunnel bytes taken")
      for (int i = 0; i < 17000 && u_host.rxq.size() < 3; i++)
         @(negedge clk);
      `CHK(u_host.rxq[0], 8'hA5, "event byte")
      `CHK(u_host.rxq[1], 8'hC1, "tx byte 0")
      `CHK(u_host.rxq[2], 8'hC2, "tx byte 1")
      `CHK(elo, 1'b0, "event pulse stuck")
   endtask : t_tunnel

   task automatic t_fill_sync;
      int         n;
      logic       got;
      logic [7:0] b;
      op_mode = THS_MODE_RF;
      push_seq(8'h40, 34, n);
      `CHK(n, 32, "fifo depth")
      `CHK(tx_ready, 1'b0, "full fifo ready")
      fork
         u_host.uart_send(8'h11, 1'b1);
         wait_rx(6000, got);
      join
      `CHK(got, 1'b0, "rx in rf mode")
      `CHK(dlo, 1'b0, "line pulled in rf mode")
      sel_strap = 1'b1;
      repeat (6) @(negedge clk);
      `CHK(sync_mode, 1'b1, "strap high not synchronous")
      op_mode = THS_MODE_SERIAL;
      for (int i = 0; i < 32; i++)
      begin
         repeat (8) @(negedge clk);
         u_host.sync_read(b);
         `CHK(b, 8'h40 + 8'(i), "sync tx byte")
      end
      repeat (8) @(negedge clk);
      `CHK(tx_ready, 1'b1, "fifo not drained")
      fork
         u_host.sync_write(8'h96);
         wait_rx(100, got);
      join
      `CHK(got, 1'b1, "sync byte missing")
      `CHK(rx_data, 8'h96, "sync rx byte")
   endtask : t_fill_sync

   // about 35000 cycles of traffic expected
   initial
   begin
      #3000000;
      failures++;
      conclude();
   end

   initial
   begin
      repeat (8) @(negedge clk);
      srst = 1'b0;
      repeat (3) @(negedge clk);
      t_uart_rx();
      t_tunnel();
      t_fill_sync();
      conclude();
   end
endmodule : tag_host_serial_port_bench

`default_nettype wire

// ### verification/ths_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module ths_host_model
(
   input  wire logic clk,
   input  wire logic sync,
   input  wire logic dev_low_oe,
   input  wire logic dev_high_oe,
   output logic      rx_pin,
   output logic      line
);
   logic       host_low = 1'b0;
   logic [7:0] ub;
   logic [7:0] rxq [$];
   assign line = !(dev_low_oe || dev_high_oe || host_low);
   initial rx_pin = 1'b1;

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : wait_cyc

   // uart frame, 520 cycles a bit
   task automatic uart_send(input logic [7:0] b, input logic stop);
      for (int i = 0; i < 10; i++)
      begin
         rx_pin = (i == 0) ? 1'b0 : (i == 9) ? stop : b[i-1];
         wait_cyc(520);
      end
      rx_pin = 1'b1;
   endtask : uart_send

   // host drives data only when writing
   task automatic sync_write(input logic [7:0] b);
      for (int i = 0; i < 8; i++)
      begin
         rx_pin = 1'b0;
         host_low = !b[i];
         wait_cyc(4);
         rx_pin = 1'b1;
         wait_cyc(4);
      end
      host_low = 1'b0;
   endtask : sync_write

   task automatic sync_read(output logic [7:0] b);
      for (int i = 0; i < 8; i++)
      begin
         rx_pin = 1'b0;
         wait_cyc(4);
         rx_pin = 1'b1;
         b[i] = line;
         wait_cyc(4);
      end
   endtask : sync_read

   // uart receiver only when strap is low
   always
   begin
      @(negedge line);
      if (!sync)
      begin
         wait_cyc(260);
         for (int i = 0; i < 8; i++)
         begin
            wait_cyc(520);
            ub[i] = line;
         end
         wait_cyc(520);
         rxq.push_back(ub);
      end
   end
endmodule : ths_host_model

`default_nettype wire

// ### verification/ths_port_properties.sv
`timescale 1ns/100ps
`default_nettype none

module ths_port_properties
(
   input wire logic       clk,
   input wire logic       srst,
   input wire logic [1:0] op_mode,
   input wire logic       tunnel_cmd,
   input wire logic       data_out_low_volt_out,
   input wire logic       data_out_high_volt_out,
   input wire logic       data_out_low_volt_oe,
   input wire logic       data_out_high_volt_oe,
   input wire logic       event_out_low_volt_out,
   input wire logic       event_out_high_volt_out,
   input wire logic       event_out_low_volt_oe,
   input wire logic       event_out_high_volt_oe,
   input wire logic       rx_valid,
   input wire logic       sync_mode
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   logic [15:0] run;
   logic [4:0]  evt;
   logic        trig;
   assign trig = tunnel_cmd && op_mode == 2'b10;
   // length of the current low-pull on the data line
   always_ff @(posedge clk)
      run <= (srst || !data_out_low_volt_oe) ? 16'h0 : run + 16'h1;
   // event pulse length, restarted by a new command
   always_ff @(posedge clk)
      evt <= (srst || trig || !event_out_low_volt_oe) ? 5'h0 : evt + 5'h1;

   chk_pins_low: assert property (
      !(data_out_low_volt_out || data_out_high_volt_out || event_out_low_volt_out
        || event_out_high_volt_out)) else $error("output driven high");
   chk_data_pair: assert property (
      data_out_low_volt_oe == data_out_high_volt_oe) else $error("data variants differ");
   chk_event_pair: assert property (
      event_out_low_volt_oe == event_out_high_volt_oe) else $error("event variants differ");
   chk_event_cause: assert property (
      $rose(event_out_low_volt_oe) |-> $past(trig)) else $error("event without command");
   chk_event_start: assert property (
      trig |=> event_out_low_volt_oe [*8]) else $error("event pulse not started");
   chk_event_width: assert property (
      $fell(event_out_low_volt_oe) |-> evt == 5'd20) else $error("event width wrong");
   chk_event_bound: assert property (
      evt <= 5'd20) else $error("event pulse too long");
   chk_uart_bit: assert property (
      $fell(data_out_low_volt_oe) && !sync_mode |-> run % 16'd520 == 16'h0)
      else $error("uart bit time wrong");
   chk_rf_quiet: assert property (
      (op_mode == 2'b00) [*3] |-> !data_out_low_volt_oe && !rx_valid)
      else $error("port active in rf mode");
   chk_rx_single: assert property (
      rx_valid |=> !rx_valid) else $error("rx_valid longer than one cycle");

   cover property (trig);
   cover property ($fell(data_out_low_volt_oe) && !sync_mode);
   cover property (rx_valid && sync_mode);
endmodule : ths_port_properties

bind tag_host_serial_port ths_port_properties u_chk (.clk, .srst, .op_mode, .tunnel_cmd,
   .data_out_low_volt_out, .data_out_high_volt_out, .data_out_low_volt_oe,
   .data_out_high_volt_oe, .event_out_low_volt_out, .event_out_high_volt_out,
   .event_out_low_volt_oe, .event_out_high_volt_oe, .rx_valid, .sync_mode);

`default_nettype wire
